/* File: design/abe_exec.v */
/*
  execution unit for the arithmetic, logic and branch groups: register file,
  status flags, program counter and multi-cycle sequencing.
  assumes the fetch side holds op and operands steady from start until done,
  and supplies the length of the following instruction for skips.
*/
// Contract
// - add registers, optional carry, five flags, 1 cycle
// - add constant to register pair, 2 cycles
// - subtract constant from register pair, 2 cycles
// - subtract registers, optional borrow, 1 cycle
// - subtract constant, optional borrow, 1 cycle
// - and/or/xor register or constant, z n v
// - set or clear mask bits, z n v
// - test, zero, fill ones register
// - increment/decrement, carry untouched, 1 cycle
// - relative jump/call: pc plus offset plus one
// - pointer jump loads pc, 2 cycles
// - pointer call loads pc, 3 cycles
// - compare skip equal advances pc 1, or 2 or 3 when equal
`timescale 1ns/1ps
`include "abe_consts.vh"

module abe_exec #(
  parameter NREGS = 32,
  parameter PTRLO = 30
) (
  input  wire        sys_clk_in,     // core clock, 20 MHz
  input  wire        rst_n_in,       // asynchronous reset, active low
  input  wire        start_in,       // pulse: take a new instruction
  input  wire [4:0]  op_in,          // operation code
  input  wire [4:0]  dst_sel_in,     // destination (or pair low) register
  input  wire [4:0]  src_sel_in,     // source register
  input  wire        use_const_in,   // use const_in in place of source
  input  wire [7:0]  const_in,       // constant operand
  input  wire [11:0] offset_in,      // signed relative offset
  input  wire        next_long_in,   // following instruction is two words
  input  wire [4:0]  rd_sel_in,      // register file read port select
  output wire        busy_out,       // instruction in progress
  output reg         done_q_out,     // pulse: last cycle finished
  output reg  [15:0] pc_q_out,       // program counter
  output reg  [7:0]  flags_q_out,    // status flags
  output reg  [7:0]  rd_data_q_out   // register file read data
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_HI   = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg [2:0]  state_q;
  reg [1:0]  wait_q;
  reg [7:0]  regs_q [0:NREGS-1];
  reg [4:0]  op_q;
  reg [4:0]  dsel_q;
  reg        c_lo_q;
  reg        z_lo_q;
  integer    i;

  function [15:0] rel_target;
    input [15:0] pc;
    input [11:0] k;
    begin
      rel_target = pc + {{4{k[11]}}, k} + 16'h0001;
    end
  endfunction

  // program counter step by a small count; wraps like the counter itself
  function [15:0] pc_plus;
    input [15:0] pc;
    input [1:0]  n;
    begin
      pc_plus = pc + {14'h0000, n};
    end
  endfunction

  // ----------------------------------------------------------------
  // operand selection and datapath
  // ----------------------------------------------------------------
  wire [7:0] dst_v = regs_q[dst_sel_in];
  wire [7:0] src_v = use_const_in ? const_in : regs_q[src_sel_in];
  wire [7:0] alu_res;
  wire [5:0] alu_flags;
  wire [5:0] alu_mask;
  wire       alu_wr;

  abe_alu8 u_alu (
    .op_in     (op_in),
    .dst_in    (dst_v),
    .src_in    (src_v),
    .carry_in  (flags_q_out[`ABE_F_C]),
    .res_out   (alu_res),
    .flags_out (alu_flags),
    .fmask_out (alu_mask),
    .wr_out    (alu_wr)
  );

  wire is_word   = (op_in == `ABE_OP_ADD_WORD) || (op_in == `ABE_OP_SUB_WORD);
  wire word_sub  = (op_q == `ABE_OP_SUB_WORD);
  wire [7:0] lo_v = regs_q[dst_sel_in];
  wire [8:0] lo_sum = (op_in == `ABE_OP_SUB_WORD) ? ({1'b0, lo_v} - {1'b0, const_in}) :
                                                ({1'b0, lo_v} + {1'b0, const_in});
  wire [7:0] hi_v = regs_q[dsel_q + 5'd1];
  wire [8:0] hi_sum = word_sub ? ({1'b0, hi_v} - {8'h00, c_lo_q}) :
                                 ({1'b0, hi_v} + {8'h00, c_lo_q});
  wire [7:0] hi_res = hi_sum[7:0];
  wire       hi_v_f = word_sub ? (hi_v[7] & ~hi_res[7]) : (~hi_v[7] & hi_res[7]);
  wire [15:0] ptr = {regs_q[PTRLO+1], regs_q[PTRLO]};
  wire        equal = (regs_q[dst_sel_in] == regs_q[src_sel_in]);

  assign busy_out = (state_q != ST_IDLE);

  // ----------------------------------------------------------------
  // flag merge: only the flags the operation owns change
  // ----------------------------------------------------------------
  wire [5:0] flags_next = (flags_q_out[5:0] & ~alu_mask) | (alu_flags & alu_mask);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q       <= ST_IDLE;
      wait_q        <= 2'd0;
      op_q          <= 5'h00;
      dsel_q        <= 5'h00;
      c_lo_q        <= 1'b0;
      z_lo_q        <= 1'b0;
      done_q_out    <= 1'b0;
      pc_q_out      <= `ABE_PC_RST;
      flags_q_out   <= `ABE_SFLAGS_RST;
      rd_data_q_out <= 8'h00;
      for (i = 0; i < NREGS; i = i + 1)
        regs_q[i] <= 8'h00;
    end else begin
      done_q_out    <= 1'b0;
      rd_data_q_out <= regs_q[rd_sel_in];
      case (state_q)
        ST_IDLE: begin
          if (start_in) begin
            op_q   <= op_in;
            dsel_q <= dst_sel_in;
            if (is_word) begin
              regs_q[dst_sel_in] <= lo_sum[7:0];
              c_lo_q <= lo_sum[8];
              z_lo_q <= (lo_sum[7:0] == 8'h00);
              state_q <= ST_HI;
            end else begin
              case (op_in)
                `ABE_OP_REL_JUMP: begin
                  pc_q_out <= rel_target(pc_q_out, offset_in);
                  wait_q   <= `ABE_CYC_TWO - 2'd1;
                  state_q  <= ST_WAIT;
                end
                `ABE_OP_REL_CALL: begin
                  pc_q_out <= rel_target(pc_q_out, offset_in);
                  wait_q   <= `ABE_CYC_THREE - 2'd1;
                  state_q  <= ST_WAIT;
                end
                `ABE_OP_PTR_JUMP: begin
                  pc_q_out <= ptr;
                  wait_q   <= `ABE_CYC_TWO - 2'd1;
                  state_q  <= ST_WAIT;
                end
                `ABE_OP_PTR_CALL: begin
                  pc_q_out <= ptr;
                  wait_q   <= `ABE_CYC_THREE - 2'd1;
                  state_q  <= ST_WAIT;
                end
                `ABE_OP_SKIP_EQ: begin
                  if (equal) begin
                    pc_q_out <= pc_plus(pc_q_out, next_long_in ? 2'd3 : 2'd2);
                    wait_q   <= next_long_in ? (`ABE_CYC_THREE - 2'd1) : (`ABE_CYC_TWO - 2'd1);
                    state_q  <= ST_WAIT;
                  end else begin
                    pc_q_out   <= pc_q_out + 16'h0001;
                    done_q_out <= 1'b1;
                  end
                end
                default: begin
                  if (alu_wr)
                    regs_q[dst_sel_in] <= alu_res;
                  flags_q_out[5:0] <= flags_next;
                  pc_q_out   <= pc_plus(pc_q_out, 2'd1);
                  done_q_out <= 1'b1;
                end
              endcase
            end
          end
        end
        ST_HI: begin
          regs_q[dsel_q + 5'd1] <= hi_res;
          flags_q_out[`ABE_F_C] <= hi_sum[8];
          flags_q_out[`ABE_F_Z] <= z_lo_q & (hi_res == 8'h00);
          flags_q_out[`ABE_F_N] <= hi_res[7];
          flags_q_out[`ABE_F_V] <= hi_v_f;
          flags_q_out[`ABE_F_S] <= hi_res[7] ^ hi_v_f;
          pc_q_out   <= pc_q_out + 16'h0001;
          done_q_out <= 1'b1;
          state_q    <= ST_IDLE;
        end
        ST_WAIT: begin
          // pc already moved at the take edge; only the cycle count remains
          if (wait_q == 2'd1) begin
            done_q_out <= 1'b1;
            state_q    <= ST_IDLE;
          end
          wait_q <= wait_q - 2'd1;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // abe_exec

/* File: design/abe_consts.vh */
/*
  constants for the alu and branch execute block: operation codes, flag
  positions, cycle counts and fixed values.
  assumes inclusion by bare name from design files.
*/
`ifndef ABE_CONSTS_VH
`define ABE_CONSTS_VH

// operation codes (5 bits)
`define ABE_OP_ADD      5'h00
`define ABE_OP_ADC      5'h01
`define ABE_OP_ADD_WORD 5'h02
`define ABE_OP_SUB      5'h03
`define ABE_OP_SUBK     5'h04
`define ABE_OP_SUB_BRW  5'h05
`define ABE_OP_SUBK_BRW 5'h06
`define ABE_OP_SUB_WORD 5'h07
`define ABE_OP_AND      5'h08
`define ABE_OP_ANDK     5'h09
`define ABE_OP_OR       5'h0a
`define ABE_OP_ORK      5'h0b
`define ABE_OP_XOR      5'h0c
`define ABE_OP_SETM     5'h0d
`define ABE_OP_CLRM     5'h0e
`define ABE_OP_INC      5'h0f
`define ABE_OP_DECR     5'h10
`define ABE_OP_TEST     5'h11
`define ABE_OP_ZERO     5'h12
`define ABE_OP_FILL     5'h13
`define ABE_OP_REL_JUMP 5'h14
`define ABE_OP_PTR_JUMP 5'h15
`define ABE_OP_REL_CALL 5'h16
`define ABE_OP_PTR_CALL 5'h17
`define ABE_OP_SKIP_EQ  5'h18

// status flag positions
`define ABE_F_C         0
`define ABE_F_Z         1
`define ABE_F_N         2
`define ABE_F_V         3
`define ABE_F_S         4
`define ABE_F_H         5

// cycle counts
`define ABE_CYC_ONE     2'd1
`define ABE_CYC_TWO     2'd2
`define ABE_CYC_THREE   2'd3

// fixed values
`define ABE_ALL_ONES    8'hff
`define ABE_SFLAGS_RST  8'h00
`define ABE_PC_RST      16'h0000

`endif

/* File: design/abe_alu8.v */
/*
  8-bit arithmetic and logic datapath: result and flag set for one operation.
  assumes operands are stable for the cycle; purely combinational.
*/
`timescale 1ns/1ps
`include "abe_consts.vh"

module abe_alu8 (
  input  wire [4:0] op_in,      // operation code
  input  wire [7:0] dst_in,     // destination operand
  input  wire [7:0] src_in,     // source register or constant
  input  wire       carry_in,   // incoming carry flag
  output reg  [7:0] res_out,    // result byte
  output reg  [5:0] flags_out,  // flags computed, flag positions
  output reg  [5:0] fmask_out,  // which flags this operation updates
  output reg        wr_out      // result is written back
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  reg [8:0] sum;
  reg       cin;

  always @* begin
    res_out   = 8'h00;
    flags_out = 6'h00;
    fmask_out = 6'h00;
    wr_out    = 1'b1;
    sum       = 9'h000;
    cin       = 1'b0;
    case (op_in)
      `ABE_OP_ADD, `ABE_OP_ADC: begin
        cin = (op_in == `ABE_OP_ADC) ? carry_in : 1'b0;
        sum = {1'b0, dst_in} + {1'b0, src_in} + {8'h00, cin};
        res_out = sum[7:0];
        flags_out[`ABE_F_C] = sum[8];
        flags_out[`ABE_F_H] = (dst_in[3] & src_in[3]) | (src_in[3] & ~res_out[3]) |
                              (~res_out[3] & dst_in[3]);
        flags_out[`ABE_F_V] = (dst_in[7] & src_in[7] & ~res_out[7]) |
                              (~dst_in[7] & ~src_in[7] & res_out[7]);
        fmask_out = 6'h2f;
      end
      `ABE_OP_SUB, `ABE_OP_SUBK, `ABE_OP_SUB_BRW, `ABE_OP_SUBK_BRW: begin
        cin = (op_in == `ABE_OP_SUB_BRW || op_in == `ABE_OP_SUBK_BRW) ? carry_in : 1'b0;
        sum = {1'b0, dst_in} - {1'b0, src_in} - {8'h00, cin};
        res_out = sum[7:0];
        flags_out[`ABE_F_C] = sum[8];
        flags_out[`ABE_F_H] = (~dst_in[3] & src_in[3]) | (src_in[3] & res_out[3]) |
                              (res_out[3] & ~dst_in[3]);
        flags_out[`ABE_F_V] = (dst_in[7] & ~src_in[7] & ~res_out[7]) |
                              (~dst_in[7] & src_in[7] & res_out[7]);
        fmask_out = 6'h2f;
      end
      `ABE_OP_AND, `ABE_OP_ANDK, `ABE_OP_TEST: begin
        res_out   = (op_in == `ABE_OP_TEST) ? dst_in : (dst_in & src_in);
        fmask_out = 6'h0e;
        wr_out    = (op_in != `ABE_OP_TEST);
      end
      `ABE_OP_OR, `ABE_OP_ORK, `ABE_OP_SETM: begin
        res_out   = dst_in | src_in;
        fmask_out = 6'h0e;
      end
      `ABE_OP_XOR, `ABE_OP_ZERO: begin
        res_out   = (op_in == `ABE_OP_ZERO) ? 8'h00 : (dst_in ^ src_in);
        fmask_out = 6'h0e;
      end
      `ABE_OP_CLRM: begin
        res_out   = dst_in & (`ABE_ALL_ONES - src_in);
        fmask_out = 6'h0e;
      end
      `ABE_OP_INC: begin
        res_out   = dst_in + 8'h01;
        flags_out[`ABE_F_V] = (dst_in == 8'h7f);
        fmask_out = 6'h0e;
      end
      `ABE_OP_DECR: begin
        res_out   = dst_in - 8'h01;
        flags_out[`ABE_F_V] = (dst_in == 8'h80);
        fmask_out = 6'h0e;
      end
      `ABE_OP_FILL: begin
        res_out   = `ABE_ALL_ONES;
      end
      default: begin
        wr_out = 1'b0;
      end
    endcase
    flags_out[`ABE_F_Z] = (res_out == 8'h00);
    flags_out[`ABE_F_N] = res_out[7];
    flags_out[`ABE_F_S] = res_out[7] ^ flags_out[`ABE_F_V];
  end

endmodule // abe_alu8

/* File: sim/abe_exec_checker.sv */
/*
  checker for the execution unit: timing, program counter and flag relations.
  assumes it is bound to abe_exec and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "abe_consts.vh"

module abe_exec_checker #(
  parameter NREGS = 32,
  parameter PTRLO = 30
) (
  input logic        sys_clk_in,    // core clock
  input logic        rst_n_in,      // reset, active low
  input logic        start_in,      // take pulse
  input logic [4:0]  op_in,         // operation code
  input logic [4:0]  dst_sel_in,    // destination select
  input logic [4:0]  src_sel_in,    // source select
  input logic        use_const_in,  // constant source
  input logic [7:0]  const_in,      // constant
  input logic [11:0] offset_in,     // relative offset
  input logic        next_long_in,  // next is two words
  input logic [4:0]  rd_sel_in,     // read select
  input logic        busy_out,      // in progress
  input logic        done_q_out,    // completion pulse
  input logic [15:0] pc_q_out,      // program counter
  input logic [7:0]  flags_q_out,   // status flags
  input logic [7:0]  rd_data_q_out  // read data
);
  // ------------------------------------------------------------
  // helper terms
  // ------------------------------------------------------------
  wire        take    = start_in && !busy_out;
  wire        word_op = (op_in == `ABE_OP_ADD_WORD) || (op_in == `ABE_OP_SUB_WORD);
  wire        one_cyc = (op_in <= `ABE_OP_FILL) && !word_op;
  wire        pm1     = (op_in == `ABE_OP_INC) || (op_in == `ABE_OP_DECR);
  wire [15:0] rel_tgt = pc_q_out + {{4{offset_in[11]}}, offset_in} + 16'h0001;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  one_cycle_ops_a: assert property (
    take && one_cyc |=> done_q_out && !busy_out && pc_q_out == $past(pc_q_out) + 16'h0001)
    else $error("one-cycle op timing or pc step wrong");
  word_timing_a: assert property (
    take && word_op |=> busy_out && !done_q_out ##1 done_q_out && !busy_out)
    else $error("word op not done in two cycles");
  rel_target_a: assert property (
    take && (op_in == `ABE_OP_REL_JUMP || op_in == `ABE_OP_REL_CALL) |=> pc_q_out == $past(rel_tgt))
    else $error("relative target wrong");
  jump_timing_a: assert property (
    take && (op_in == `ABE_OP_REL_JUMP || op_in == `ABE_OP_PTR_JUMP)
    |=> busy_out ##1 done_q_out && !busy_out)
    else $error("jump not done in two cycles");
  call_timing_a: assert property (
    take && (op_in == `ABE_OP_REL_CALL || op_in == `ABE_OP_PTR_CALL) |=> busy_out[*2] ##1 done_q_out)
    else $error("call not done in three cycles");
  flags_kept_a: assert property (
    take && (op_in >= `ABE_OP_REL_JUMP || op_in == `ABE_OP_FILL) |=> $stable(flags_q_out))
    else $error("flags changed by a flag-free op");
  carry_kept_a: assert property (
    take && pm1 |=> flags_q_out[`ABE_F_C] == $past(flags_q_out[`ABE_F_C]))
    else $error("carry changed by increment or decrement");
  skip_step_a: assert property (
    take && op_in == `ABE_OP_SKIP_EQ |=> (pc_q_out == $past(pc_q_out) + 16'h0001 && done_q_out)
    or (pc_q_out == $past(pc_q_out) + 16'h0002 && busy_out ##1 done_q_out)
    or (pc_q_out == $past(pc_q_out) + 16'h0003 && busy_out[*2] ##1 done_q_out))
    else $error("skip step or timing wrong");
  done_cause_a: assert property (
    done_q_out |-> $past(start_in) || $past(busy_out))
    else $error("done without an instruction");
endmodule // abe_exec_checker

bind abe_exec abe_exec_checker #(.NREGS(NREGS), .PTRLO(PTRLO)) chk_u (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(start_in), .op_in(op_in),
  .dst_sel_in(dst_sel_in), .src_sel_in(src_sel_in), .use_const_in(use_const_in),
  .const_in(const_in), .offset_in(offset_in), .next_long_in(next_long_in),
  .rd_sel_in(rd_sel_in), .busy_out(busy_out), .done_q_out(done_q_out),
  .pc_q_out(pc_q_out), .flags_q_out(flags_q_out), .rd_data_q_out(rd_data_q_out));

/* File: sim/alu_and_branch_execute_test.sv */
/*
  self-checking bench for the execution unit, one task per scenario.
  assumes the checker is bound in and registers start at zero after reset.
*/
`timescale 1ns/1ps
`include "abe_consts.vh"

module alu_and_branch_execute_test;
  reg         sys_clk_in   = 1'b0;
  reg         rst_n_in     = 1'b0;
  reg         start_in     = 1'b0;
  reg  [4:0]  op_in        = 5'h00;
  reg  [4:0]  dst_sel_in   = 5'h00;
  reg  [4:0]  src_sel_in   = 5'h00;
  reg         use_const_in = 1'b0;
  reg  [7:0]  const_in     = 8'h00;
  reg  [11:0] offset_in    = 12'h000;
  reg         next_long_in = 1'b0;
  reg  [4:0]  rd_sel_in    = 5'h00;
  wire        busy_out;
  wire        done_q_out;
  wire [15:0] pc_q_out;
  wire [7:0]  flags_q_out;
  wire [7:0]  rd_data_q_out;
  integer     n_mismatch   = 0;
  integer     num_checks   = 0;

  always #25 sys_clk_in = ~sys_clk_in;

  abe_exec dut_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(start_in), .op_in(op_in),
    .dst_sel_in(dst_sel_in), .src_sel_in(src_sel_in), .use_const_in(use_const_in),
    .const_in(const_in), .offset_in(offset_in), .next_long_in(next_long_in),
    .rd_sel_in(rd_sel_in), .busy_out(busy_out), .done_q_out(done_q_out),
    .pc_q_out(pc_q_out), .flags_q_out(flags_q_out), .rd_data_q_out(rd_data_q_out));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  task chk(input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // one instruction; counts cycles from take to done, then idles a cycle
  task automatic ex(input [4:0] op, input [4:0] d, input [4:0] s, input uc,
                    input [7:0] k, input [11:0] off, input nl, input [15:0] cyc);
    integer n;
    begin
      op_in = op;
      dst_sel_in = d;
      src_sel_in = s;
      use_const_in = uc;
      const_in = k;
      offset_in = off;
      next_long_in = nl;
      start_in = 1'b1;
      @(posedge sys_clk_in);
      #1 start_in = 1'b0;
      n = 1;
      while (done_q_out !== 1'b1 && n < 8) begin
        @(posedge sys_clk_in);
        #1 n = n + 1;
      end
      if (n == 8) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t ns: no done", $time);
        report_and_stop;
      end else begin
        chk(n[15:0], cyc);
        @(posedge sys_clk_in);
        #1;
      end
    end
  endtask

  task rdchk(input [4:0] r, input [7:0] e);
    begin
      rd_sel_in = r;
      @(posedge sys_clk_in);
      #1 chk({8'h00, rd_data_q_out}, {8'h00, e});
    end
  endtask

  task setr(input [4:0] r, input [7:0] v);
    begin
      ex(`ABE_OP_ZERO, r, 5'h00, 1'b0, 8'h00, 12'h000, 1'b0, 16'd1);
      ex(`ABE_OP_ORK, r, 5'h00, 1'b1, v, 12'h000, 1'b0, 16'd1);
    end
  endtask

  task op1(input [4:0] op, input [4:0] d, input [4:0] s, input uc, input [7:0] k,
           input [7:0] res, input [7:0] msk, input [7:0] fl);
    begin
      ex(op, d, s, uc, k, 12'h000, 1'b0, 16'd1);
      rdchk(d, res);
      chk({8'h00, flags_q_out & msk}, {8'h00, fl});
    end
  endtask

  task br(input [4:0] op, input [4:0] d, input [4:0] s, input [11:0] off, input nl,
          input [15:0] cyc, input [15:0] pc);
    begin
      ex(op, d, s, 1'b0, 8'h00, off, nl, cyc);
      chk(pc_q_out, pc);
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_arith;
    begin
      setr(5'd1, 8'h7f);
      setr(5'd2, 8'h01);
      op1(`ABE_OP_ADD, 5'd1, 5'd2, 1'b0, 8'h00, 8'h80, 8'h3f, 8'h2c);
      op1(`ABE_OP_FILL, 5'd3, 5'd0, 1'b0, 8'h00, 8'hff, 8'h00, 8'h00);
      op1(`ABE_OP_ADD, 5'd3, 5'd2, 1'b0, 8'h00, 8'h00, 8'h3f, 8'h23);
      op1(`ABE_OP_ADC, 5'd2, 5'd2, 1'b0, 8'h00, 8'h03, 8'h3f, 8'h00);
      setr(5'd5, 8'h10);
      setr(5'd6, 8'h20);
      op1(`ABE_OP_SUB, 5'd5, 5'd6, 1'b0, 8'h00, 8'hf0, 8'h3f, 8'h05);
      op1(`ABE_OP_SUB_BRW, 5'd5, 5'd6, 1'b0, 8'h00, 8'hcf, 8'h3f, 8'h24);
      op1(`ABE_OP_SUBK, 5'd5, 5'd0, 1'b1, 8'hcf, 8'h00, 8'h3f, 8'h02);
      op1(`ABE_OP_SUBK_BRW, 5'd5, 5'd0, 1'b1, 8'h01, 8'hff, 8'h3f, 8'h25);
      $display("end of t_arith");
    end
  endtask

  // carry stays set from t_arith, so c in the mask shows it is left alone
  task t_logic;
    begin
      setr(5'd8, 8'hc3);
      setr(5'd7, 8'h3c);
      op1(`ABE_OP_AND, 5'd7, 5'd8, 1'b0, 8'h00, 8'h00, 8'h0f, 8'h03);
      op1(`ABE_OP_OR, 5'd7, 5'd8, 1'b0, 8'h00, 8'hc3, 8'h0f, 8'h05);
      op1(`ABE_OP_XOR, 5'd7, 5'd8, 1'b0, 8'h00, 8'h00, 8'h0f, 8'h03);
      op1(`ABE_OP_SETM, 5'd7, 5'd0, 1'b1, 8'h81, 8'h81, 8'h0f, 8'h05);
      op1(`ABE_OP_CLRM, 5'd7, 5'd0, 1'b1, 8'h80, 8'h01, 8'h0f, 8'h01);
      op1(`ABE_OP_ANDK, 5'd7, 5'd0, 1'b1, 8'h01, 8'h01, 8'h0f, 8'h01);
      op1(`ABE_OP_DECR, 5'd7, 5'd0, 1'b0, 8'h00, 8'h00, 8'h0f, 8'h03);
      op1(`ABE_OP_DECR, 5'd7, 5'd0, 1'b0, 8'h00, 8'hff, 8'h0f, 8'h05);
      op1(`ABE_OP_INC, 5'd7, 5'd0, 1'b0, 8'h00, 8'h00, 8'h0f, 8'h03);
      op1(`ABE_OP_ORK, 5'd7, 5'd0, 1'b1, 8'h7f, 8'h7f, 8'h0f, 8'h01);
      op1(`ABE_OP_INC, 5'd7, 5'd0, 1'b0, 8'h00, 8'h80, 8'h0f, 8'h0d);
      op1(`ABE_OP_DECR, 5'd7, 5'd0, 1'b0, 8'h00, 8'h7f, 8'h0f, 8'h09);
      op1(`ABE_OP_TEST, 5'd7, 5'd0, 1'b0, 8'h00, 8'h7f, 8'h0f, 8'h01);
      op1(`ABE_OP_ZERO, 5'd7, 5'd0, 1'b0, 8'h00, 8'h00, 8'h0f, 8'h03);
      op1(`ABE_OP_FILL, 5'd7, 5'd0, 1'b0, 8'h00, 8'hff, 8'h0f, 8'h03);
      $display("end of t_logic");
    end
  endtask

  task t_word;
    begin
      setr(5'd24, 8'hff);
      setr(5'd25, 8'h7f);
      ex(`ABE_OP_ADD_WORD, 5'd24, 5'd0, 1'b1, 8'h01, 12'h000, 1'b0, 16'd2);
      chk({8'h00, flags_q_out & 8'h1f}, 16'h000c);
      rdchk(5'd24, 8'h00);
      rdchk(5'd25, 8'h80);
      ex(`ABE_OP_SUB_WORD, 5'd24, 5'd0, 1'b1, 8'h01, 12'h000, 1'b0, 16'd2);
      chk({8'h00, flags_q_out & 8'h1f}, 16'h0018);
      rdchk(5'd24, 8'hff);
      rdchk(5'd25, 8'h7f);
      $display("end of t_word");
    end
  endtask

  task t_branch;
    begin
      setr(5'd30, 8'h34);
      setr(5'd31, 8'h12);
      br(`ABE_OP_PTR_JUMP, 5'd0, 5'd0, 12'h000, 1'b0, 16'd2, 16'h1234);
      br(`ABE_OP_REL_JUMP, 5'd0, 5'd0, 12'h005, 1'b0, 16'd2, 16'h123a);
      br(`ABE_OP_REL_JUMP, 5'd0, 5'd0, 12'hff0, 1'b0, 16'd2, 16'h122b);
      br(`ABE_OP_REL_CALL, 5'd0, 5'd0, 12'h800, 1'b0, 16'd3, 16'h0a2c);
      br(`ABE_OP_PTR_CALL, 5'd0, 5'd0, 12'h000, 1'b0, 16'd3, 16'h1234);
      br(`ABE_OP_SKIP_EQ, 5'd30, 5'd31, 12'h000, 1'b0, 16'd1, 16'h1235);
      br(`ABE_OP_SKIP_EQ, 5'd30, 5'd30, 12'h000, 1'b0, 16'd2, 16'h1237);
      br(`ABE_OP_SKIP_EQ, 5'd31, 5'd31, 12'h000, 1'b1, 16'd3, 16'h123a);
      $display("end of t_branch");
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk_in);
    #1 rst_n_in = 1'b1;
    t_arith;
    t_logic;
    t_word;
    t_branch;
    report_and_stop;
  end
endmodule // alu_and_branch_execute_test
